// ==== hw/cam_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cam_defs.svh"
module cam_top #(
    parameter int SYNC_STAGES = `CAM_SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sec_tick_pin,
    input wire logic countdown_flag,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata_q,
    output logic match_flag_q,
    output logic irq_q
);
    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    generate
        if (SYNC_STAGES < 2) begin : g_bad
            $error("SYNC_STAGES must be at least 2");
        end
    endgenerate

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [SYNC_STAGES-1:0] sync_q;
    logic tick_last_q;
    logic tick_pulse;
    cam_pkg::cam_tick_type state_q;
    logic [6:0] sec_q;
    logic [6:0] min_q;
    logic [5:0] hour_q;
    logic [5:0] day_q;
    logic [2:0] wday_q;
    logic [4:0] mon_q;
    logic cent_q;
    logic [7:0] year_q;
    logic [7:0] amin_q;
    logic [7:0] ahour_q;
    logic [7:0] aday_q;
    logic [7:0] awday_q;
    logic match_irq_enable_q;
    logic countdown_irq_enable_q;
    logic match_prev_q;
    logic match_now;
    logic leap;
    logic [7:0] day_max;
    logic [7:0] fld_cur [0:6];
    logic [7:0] fld_lo [0:6];
    logic [7:0] fld_hi [0:6];
    logic [7:0] fld_nxt [0:6];
    logic [6:0] fld_en;
    logic [6:0] fld_wrap;
    logic step;
    logic wr_ctrl2;
    cam_time_if tif ();

    // ----------------------------------------
    // Seconds tick synchroniser and edge
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], sec_tick_pin};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_last_q <= 1'b0;
        end else begin
            tick_last_q <= sync_q[SYNC_STAGES-1];
        end
    end

    assign tick_pulse = sync_q[SYNC_STAGES-1] && !tick_last_q;

    // ----------------------------------------
    // Tick sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= cam_pkg::TK_IDLE;
        end else begin
            case (state_q)
                cam_pkg::TK_IDLE: begin
                    if (tick_pulse) begin
                        state_q <= cam_pkg::TK_STEP;
                    end
                end
                cam_pkg::TK_STEP: begin
                    state_q <= cam_pkg::TK_EVAL;
                end
                cam_pkg::TK_EVAL: begin
                    state_q <= cam_pkg::TK_IDLE;
                end
                default: begin
                    state_q <= cam_pkg::TK_IDLE;
                end
            endcase
        end
    end

    assign step = (state_q == cam_pkg::TK_STEP);

    // ----------------------------------------
    // Month length and leap year
    // ----------------------------------------
    always_comb begin
        if (year_q[4]) begin
            leap = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
        end else begin
            leap = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4)
                || (year_q[3:0] == 4'h8);
        end
        case ({3'h0, mon_q})
            `CAM_MON_FEB: day_max = leap ? `CAM_DAY_29 : `CAM_DAY_28;
            `CAM_MON_APR: day_max = `CAM_DAY_30;
            `CAM_MON_JUN: day_max = `CAM_DAY_30;
            `CAM_MON_SEP: day_max = `CAM_DAY_30;
            `CAM_MON_NOV: day_max = `CAM_DAY_30;
            default: day_max = `CAM_DAY_31;
        endcase
    end

    // ----------------------------------------
    // Counter chain fields
    // ----------------------------------------
    always_comb begin
        fld_cur[0] = {1'b0, sec_q};
        fld_cur[1] = {1'b0, min_q};
        fld_cur[2] = {2'h0, hour_q};
        fld_cur[3] = {2'h0, day_q};
        fld_cur[4] = {3'h0, mon_q};
        fld_cur[5] = year_q;
        fld_cur[6] = {5'h00, wday_q};
        fld_lo[0] = `CAM_RST_ZERO;
        fld_lo[1] = `CAM_RST_ZERO;
        fld_lo[2] = `CAM_RST_ZERO;
        fld_lo[3] = `CAM_RST_ONE;
        fld_lo[4] = `CAM_RST_ONE;
        fld_lo[5] = `CAM_RST_ZERO;
        fld_lo[6] = `CAM_RST_ZERO;
        fld_hi[0] = `CAM_MAX_SEC;
        fld_hi[1] = `CAM_MAX_SEC;
        fld_hi[2] = `CAM_MAX_HOUR;
        fld_hi[3] = day_max;
        fld_hi[4] = `CAM_MAX_MON;
        fld_hi[5] = `CAM_MAX_YEAR;
        fld_hi[6] = `CAM_MAX_WDAY;
    end

    always_comb begin
        fld_en[0] = step;
        fld_en[1] = fld_wrap[0];
        fld_en[2] = fld_wrap[1];
        fld_en[3] = fld_wrap[2];
        fld_en[4] = fld_wrap[3];
        fld_en[5] = fld_wrap[4];
        fld_en[6] = fld_wrap[2];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_fld
            cam_bcd_step u_step (
                .cur(fld_cur[gi]),
                .lo(fld_lo[gi]),
                .hi(fld_hi[gi]),
                .en(fld_en[gi]),
                .nxt(fld_nxt[gi]),
                .wrap(fld_wrap[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Time registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sec_q <= '0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_SEC) begin
            sec_q <= reg_wdata[6:0];
        end else if (step) begin
            sec_q <= fld_nxt[0][6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            min_q <= '0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_MIN) begin
            min_q <= reg_wdata[6:0];
        end else if (step) begin
            min_q <= fld_nxt[1][6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hour_q <= '0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_HOUR) begin
            hour_q <= reg_wdata[5:0];
        end else if (step) begin
            hour_q <= fld_nxt[2][5:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            day_q <= 6'(`CAM_RST_ONE);
        end else if (reg_wr_en && reg_addr == `CAM_OFS_DAY) begin
            day_q <= reg_wdata[5:0];
        end else if (step) begin
            day_q <= fld_nxt[3][5:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wday_q <= '0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_WDAY) begin
            wday_q <= reg_wdata[2:0];
        end else if (step) begin
            wday_q <= fld_nxt[6][2:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mon_q <= 5'(`CAM_RST_ONE);
        end else if (reg_wr_en && reg_addr == `CAM_OFS_MON) begin
            mon_q <= reg_wdata[4:0];
        end else if (step) begin
            mon_q <= fld_nxt[4][4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cent_q <= 1'b0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_MON) begin
            cent_q <= reg_wdata[`CAM_CENT_BIT];
        end else if (step && fld_wrap[5]) begin
            cent_q <= !cent_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            year_q <= '0;
        end else if (reg_wr_en && reg_addr == `CAM_OFS_YEAR) begin
            year_q <= reg_wdata;
        end else if (step) begin
            year_q <= fld_nxt[5];
        end
    end

    // ----------------------------------------
    // Match registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            amin_q <= `CAM_RST_ALARM;
            ahour_q <= `CAM_RST_ALARM;
            aday_q <= `CAM_RST_ALARM;
            awday_q <= `CAM_RST_ALARM;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `CAM_OFS_AMIN: amin_q <= reg_wdata;
                `CAM_OFS_AHOUR: ahour_q <= reg_wdata & 8'hBF;
                `CAM_OFS_ADAY: aday_q <= reg_wdata & 8'hBF;
                `CAM_OFS_AWDAY: awday_q <= reg_wdata & 8'h87;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Match compare and flag
    // ----------------------------------------
    assign tif.minute = min_q;
    assign tif.hour = hour_q;
    assign tif.day = day_q;
    assign tif.wday = wday_q;

    cam_match u_match (
        .tif(tif),
        .amin(amin_q),
        .ahour(ahour_q),
        .aday(aday_q),
        .awday(awday_q),
        .match(match_now)
    );

    assign wr_ctrl2 = reg_wr_en && (reg_addr == `CAM_OFS_CTRL2);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match_prev_q <= 1'b0;
        end else if (state_q == cam_pkg::TK_EVAL) begin
            match_prev_q <= match_now;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match_flag_q <= 1'b0;
        end else if (state_q == cam_pkg::TK_EVAL && match_now
                     && !match_prev_q) begin
            match_flag_q <= 1'b1;
        end else if (wr_ctrl2 && !reg_wdata[`CAM_AF_BIT]) begin
            match_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control bits and interrupt
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match_irq_enable_q <= 1'b0;
            countdown_irq_enable_q <= 1'b0;
        end else if (wr_ctrl2) begin
            match_irq_enable_q <= reg_wdata[`CAM_AIE_BIT];
            countdown_irq_enable_q <= reg_wdata[`CAM_TIE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (match_flag_q && match_irq_enable_q)
                || (countdown_flag && countdown_irq_enable_q);
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_q <= '0;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `CAM_OFS_CTRL2: reg_rdata_q <= {4'h0, match_flag_q,
                    countdown_flag, match_irq_enable_q,
                    countdown_irq_enable_q};
                `CAM_OFS_SEC: reg_rdata_q <= {1'b0, sec_q};
                `CAM_OFS_MIN: reg_rdata_q <= {1'b0, min_q};
                `CAM_OFS_HOUR: reg_rdata_q <= {2'h0, hour_q};
                `CAM_OFS_DAY: reg_rdata_q <= {2'h0, day_q};
                `CAM_OFS_WDAY: reg_rdata_q <= {5'h00, wday_q};
                `CAM_OFS_MON: reg_rdata_q <= {cent_q, 2'h0, mon_q};
                `CAM_OFS_YEAR: reg_rdata_q <= year_q;
                `CAM_OFS_AMIN: reg_rdata_q <= amin_q;
                `CAM_OFS_AHOUR: reg_rdata_q <= ahour_q;
                `CAM_OFS_ADAY: reg_rdata_q <= aday_q;
                `CAM_OFS_AWDAY: reg_rdata_q <= awday_q;
                default: reg_rdata_q <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hw/cam_defs.svh ====
`ifndef CAM_DEFS_SVH
`define CAM_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CAM_OFS_CTRL2 8'h01
`define CAM_OFS_SEC 8'h02
`define CAM_OFS_MIN 8'h03
`define CAM_OFS_HOUR 8'h04
`define CAM_OFS_DAY 8'h05
`define CAM_OFS_WDAY 8'h06
`define CAM_OFS_MON 8'h07
`define CAM_OFS_YEAR 8'h08
`define CAM_OFS_AMIN 8'h09
`define CAM_OFS_AHOUR 8'h0A
`define CAM_OFS_ADAY 8'h0B
`define CAM_OFS_AWDAY 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAM_DIS_BIT 7
`define CAM_CENT_BIT 7
`define CAM_AF_BIT 3
`define CAM_TF_BIT 2
`define CAM_AIE_BIT 1
`define CAM_TIE_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CAM_RST_ZERO 8'h00
`define CAM_RST_ONE 8'h01
`define CAM_RST_ALARM 8'h80

// ----------------------------------------
// Counting limits (BCD)
// ----------------------------------------
`define CAM_MAX_SEC 8'h59
`define CAM_MAX_HOUR 8'h23
`define CAM_MAX_WDAY 8'h06
`define CAM_MAX_MON 8'h12
`define CAM_MAX_YEAR 8'h99
`define CAM_DAY_31 8'h31
`define CAM_DAY_30 8'h30
`define CAM_DAY_29 8'h29
`define CAM_DAY_28 8'h28
`define CAM_MON_FEB 8'h02
`define CAM_MON_APR 8'h04
`define CAM_MON_JUN 8'h06
`define CAM_MON_SEP 8'h09
`define CAM_MON_NOV 8'h11

// ----------------------------------------
// Timing
// ----------------------------------------
`define CAM_SYNC_STAGES 2

`endif

// ==== hw/cam_pkg.sv ====
`default_nettype none
package cam_pkg;
    typedef enum logic [1:0] {
        TK_IDLE = 2'h0,
        TK_STEP = 2'h1,
        TK_EVAL = 2'h3
    } cam_tick_type;
endpackage
`default_nettype wire

// ==== hw/cam_time_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface cam_time_if;
    logic [6:0] minute;
    logic [5:0] hour;
    logic [5:0] day;
    logic [2:0] wday;
    modport src (
        output minute,
        output hour,
        output day,
        output wday
    );
    modport snk (
        input minute,
        input hour,
        input day,
        input wday
    );
endinterface
`default_nettype wire

// ==== hw/cam_bcd_step.sv ====
`timescale 1ns/1ns
`default_nettype none
module cam_bcd_step (
    input wire logic [7:0] cur,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    input wire logic en,
    output logic [7:0] nxt,
    output logic wrap
);
    // ----------------------------------------
    // BCD increment with wrap to low bound
    // ----------------------------------------
    always_comb begin
        wrap = en && (cur >= hi);
        if (!en) begin
            nxt = cur;
        end else if (wrap) begin
            nxt = lo;
        end else if (cur[3:0] >= 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = cur + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== hw/cam_match.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cam_defs.svh"
module cam_match (
    cam_time_if.snk tif,
    input wire logic [7:0] amin,
    input wire logic [7:0] ahour,
    input wire logic [7:0] aday,
    input wire logic [7:0] awday,
    output logic match
);
    logic [3:0] dis;
    logic [3:0] hit;

    // ----------------------------------------
    // Per-field compare, disabled fields pass
    // ----------------------------------------
    always_comb begin
        dis = {awday[`CAM_DIS_BIT], aday[`CAM_DIS_BIT],
               ahour[`CAM_DIS_BIT], amin[`CAM_DIS_BIT]};
        hit[0] = dis[0] || (tif.minute == amin[6:0]);
        hit[1] = dis[1] || (tif.hour == ahour[5:0]);
        hit[2] = dis[2] || (tif.day == aday[5:0]);
        hit[3] = dis[3] || (tif.wday == awday[2:0]);
        match = (&hit) && !(&dis);
    end
endmodule
`default_nettype wire

// ==== tb/cam_check_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module cam_check #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sec_tick_pin,
    input wire logic countdown_flag,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata_q,
    input wire logic match_flag_q,
    input wire logic irq_q
);
    // ----------------------------------------
    // Mirrored control state
    // ----------------------------------------
    logic aie_q;
    logic tie_q;
    logic pin_q;
    logic [3:0] dis_q;
    logic [3:0] age_q;
    logic [7:0] spare;
    logic ctl_wr;
    logic irq_c;
    assign ctl_wr = reg_wr_en && reg_addr == 8'h01;
    assign irq_c = (match_flag_q && aie_q) || (countdown_flag && tie_q);
    always_comb begin
        case (reg_addr)
            8'h01: spare = 8'hF0;
            8'h02, 8'h03: spare = 8'h80;
            8'h04, 8'h05: spare = 8'hC0;
            8'h06: spare = 8'hF8;
            8'h07: spare = 8'h60;
            8'h08, 8'h09: spare = 8'h00;
            8'h0A, 8'h0B: spare = 8'h40;
            8'h0C: spare = 8'h78;
            default: spare = 8'hFF;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aie_q <= 1'h0;
            tie_q <= 1'h0;
            dis_q <= 4'hF;
        end else if (ctl_wr) begin
            aie_q <= reg_wdata[1];
            tie_q <= reg_wdata[0];
        end else if (reg_wr_en && reg_addr >= 8'h09 && reg_addr <= 8'h0C) begin
            dis_q[reg_addr[1:0]] <= reg_wdata[7];
        end
    end
    always_ff @(posedge sys_clk) begin
        pin_q <= sec_tick_pin;
        if (rst) begin
            age_q <= 4'hF;
        end else if (sec_tick_pin && !pin_q) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hF) begin
            age_q <= age_q + 4'h1;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cam_cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    flag_hold_a: assert property (match_flag_q && !ctl_wr
        |=> match_flag_q)
        else $error("match flag fell without a clear");
    flag_keep_a: assert property (match_flag_q && ctl_wr
        && reg_wdata[3] |=> match_flag_q)
        else $error("match flag fell on a keep write");
    flag_clear_a: assert property ((!sec_tick_pin) [*8]
        ##0 (ctl_wr && !reg_wdata[3]) |=> !match_flag_q)
        else $error("match flag not cleared");
    flag_cause_a: assert property ($rose(match_flag_q)
        |-> int'(age_q) <= SYNC_STAGES + 8)
        else $error("match flag set without a tick");
    irq_gate_a: assert property (1'h1 |=> irq_q == $past(irq_c))
        else $error("interrupt not the gated flags");
    all_off_a: assert property ($rose(match_flag_q) |-> dis_q != 4'hF)
        else $error("match flag set with every field off");
    ctl_read_a: assert property (reg_rd_en && ctl_wr == 1'h0
        && reg_addr == 8'h01 |=> reg_rdata_q[3:0] == {$past(match_flag_q),
        $past(countdown_flag), aie_q, tie_q})
        else $error("control read wrong");
    spare_bits_a: assert property (reg_rd_en && !reg_wr_en
        |=> (reg_rdata_q & $past(spare)) == 8'h00)
        else $error("spare bits read nonzero");
    cover property ($rose(match_flag_q));
    cover property ($rose(irq_q));
    cover property (match_flag_q && ctl_wr && !reg_wdata[3]);
endmodule
bind cam_top cam_check #(.SYNC_STAGES(SYNC_STAGES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .sec_tick_pin(sec_tick_pin),
    .countdown_flag(countdown_flag), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rdata_q(reg_rdata_q), .match_flag_q(match_flag_q), .irq_q(irq_q)
);
`default_nettype wire

// ==== tb/cam_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cam_host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr_en,
    output logic reg_rd_en
);
    // ----------------------------------------
    // Register access, idle gap after each
    // ----------------------------------------
    int idle = 0;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'h1;
        @(posedge sys_clk);
        reg_wr_en <= 1'h0;
        reg_wdata <= ~d;
        reg_addr <= ~a;
        repeat (idle) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'h1;
        @(posedge sys_clk);
        reg_rd_en <= 1'h0;
        reg_addr <= ~a;
        repeat (idle) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/cam_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module cam_top_tb_top;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic sec_tick_pin = 1'h0;
    logic countdown_flag = 1'h0;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr_en;
    logic reg_rd_en;
    logic [7:0] reg_rdata_q;
    logic match_flag_q;
    logic irq_q;
    logic rd_seen = 1'h0;
    logic [7:0] lfsr_q = 8'h0B;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] spare [4:12] = '{8'hC0, 8'hC0, 8'hF8, 8'h60, 8'h00,
        8'h00, 8'h40, 8'h40, 8'h78};
    logic [7:0] rst_v [4:12] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
        8'h80, 8'h80, 8'h80, 8'h80};
    logic [39:0] mlen [9] = '{40'h0421300105, 40'h0204282902,
        40'h0204290103, 40'h0203280103, 40'h0200282902, 40'h0121310102,
        40'h0921300110, 40'h1121300112, 40'h0121303101};
    always #5 sys_clk = ~sys_clk;
    cam_host_model HOST (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en));
    cam_top #(.SYNC_STAGES(2)) DUT (.sys_clk(sys_clk), .rst(rst),
        .sec_tick_pin(sec_tick_pin), .countdown_flag(countdown_flag),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
        .match_flag_q(match_flag_q), .irq_q(irq_q));
    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic chk_byte(input string n, input logic [7:0] e,
        input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_bit(input string n, input logic e);
        logic s;
        @(negedge sys_clk);
        s = (n == "irq") ? irq_q : match_flag_q;
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) rd_seen <= reg_rd_en;
    always @(negedge sys_clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk_byte($sformatf("reg %h", exp_q[0][15:8]), exp_q[0][7:0],
                reg_rdata_q);
            void'(exp_q.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("timeout");
            summarize();
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        HOST.rd(a);
    endtask
    task automatic set_time(input logic [55:0] t);
        for (int i = 0; i < 7; i++) HOST.wr(8'(2 + i), t[55 - 8 * i -: 8]);
    endtask
    task automatic rd_time(input logic [55:0] t);
        for (int i = 0; i < 7; i++) rd_chk(8'(2 + i), t[55 - 8 * i -: 8]);
    endtask
    task automatic set_alarm(input logic [31:0] a);
        for (int i = 0; i < 4; i++) HOST.wr(8'(9 + i), a[31 - 8 * i -: 8]);
    endtask
    task automatic tick();
        @(posedge sys_clk);
        sec_tick_pin <= 1'h1;
        repeat (12) @(posedge sys_clk);
        sec_tick_pin <= 1'h0;
        repeat (12) @(posedge sys_clk);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        for (int i = 4; i <= 12; i++) rd_chk(8'(i), rst_v[i]);
        rd_chk(8'h0F, 8'h00);
        HOST.idle = 1;
        for (int i = 4; i <= 12; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            HOST.wr(8'(i), lfsr_q);
            rd_chk(8'(i), lfsr_q & ~spare[i]);
        end
        HOST.idle = 0;
        set_alarm(32'h80808080);
        $display("test registers done");
        for (int c = 0; c < 2; c++) begin
            set_time({40'h5959233106, c ? 8'h92 : 8'h12, 8'h99});
            tick();
            rd_time({40'h0000000100, c ? 8'h01 : 8'h81,
                8'h00});
        end
        foreach (mlen[i]) begin
            set_time({24'h595923, mlen[i][23:16], 8'h00, mlen[i][39:24]});
            tick();
            rd_time({24'h0, mlen[i][15:8], 8'h01, mlen[i][7:0],
                mlen[i][31:24]});
        end
        $display("test calendar done");
        set_time(56'h5958120503_0121);
        set_alarm(32'h59128003);
        HOST.wr(8'h01, 8'h02);
        tick();
        chk_bit("match flag", 1'h1);
        chk_bit("irq", 1'h1);
        tick();
        chk_bit("match flag", 1'h1);
        HOST.wr(8'h01, 8'h0A);
        chk_bit("match flag", 1'h1);
        rd_chk(8'h01, 8'h0A);
        HOST.wr(8'h01, 8'h08);
        repeat (2) @(posedge sys_clk);
        chk_bit("irq", 1'h0);
        HOST.wr(8'h01, 8'h02);
        chk_bit("match flag", 1'h0);
        tick();
        chk_bit("match flag", 1'h0);
        set_time(56'h5958120503_0121);
        set_alarm(32'h59128004);
        tick();
        chk_bit("match flag", 1'h0);
        set_time(56'h5958120503_0121);
        set_alarm(32'h59128084);
        tick();
        chk_bit("match flag", 1'h1);
        HOST.wr(8'h03, 8'h10);
        chk_bit("match flag", 1'h1);
        $display("test match done");
        HOST.wr(8'h01, 8'h01);
        @(posedge sys_clk);
        countdown_flag <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk_bit("irq", 1'h1);
        rd_chk(8'h01, 8'h05);
        @(posedge sys_clk);
        countdown_flag <= 1'h0;
        repeat (3) @(posedge sys_clk);
        chk_bit("irq", 1'h0);
        $display("test interrupt done");
        repeat (4) @(posedge sys_clk);
        summarize();
    end
endmodule
`default_nettype wire
